// *** rtl/fsp_poller.sv ***
// host-side controller of a parallel flash: bus cycles, status polling,
// reset commands and supply lockout handling
// assumes a 10 MHz clock, an external pull-up on the ready/busy line and
// a supervisor that reports low supply on supply_low
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "fsp_defines.svh"

module fsp_poller
  import fsp_pkg::*;
#(
  parameter int AW = 20,
  parameter int DW = 16,
  parameter logic [31:0] POLL_LIMIT = 32'(`FSP_OP_MAX_CYC)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // software port
  input wire logic [4:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  // flash pins
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_rst_n,
  output logic [AW-1:0] flash_addr,
  input wire logic [DW-1:0] dq_in,
  output logic [DW-1:0] dq_out,
  output logic dq_oe,
  input wire logic ready_busy_n,
  // supply supervisor
  input wire logic supply_low
);

  localparam logic [3:0] RD_CYC = 4'(`FSP_ACC_CYC + `FSP_SYNC_CYC);
  localparam logic [3:0] RST_CYC = 4'(`FSP_RST_CYC);

  if (DW < 8 || AW < 1 || AW > 32 || DW > 32) begin : g_bad_width
    $error("fsp_poller: AW must be 1..32 and DW 8..32");
  end
  if (POLL_LIMIT == 32'h0) begin : g_bad_limit
    $error("fsp_poller: POLL_LIMIT must be nonzero");
  end

  fsp_state_e state, next_state;
  logic [3:0] wcnt, next_wcnt;
  logic [31:0] pcnt, next_pcnt;
  logic [AW-1:0] op_addr, next_op_addr;
  logic [DW-1:0] op_wdata, next_op_wdata;
  logic [DW-1:0] rdata, next_rdata;
  logic [`FSP_ST_W-1:0] status, next_status;
  logic first_tog, next_first_tog;
  logic have_first, next_have_first;
  logic polling, next_polling;
  logic poll_after, next_poll_after;
  logic pre_pend, next_pre_pend;
  logic rst_only, next_rst_only;
  logic chk_pend, next_chk_pend;
  logic next_ce_n, next_oe_n, next_we_n, next_frst_n, next_dq_oe;
  logic [AW-1:0] next_flash_addr;
  logic [DW-1:0] next_dq_out;
  logic [31:0] next_sw_rdata;
  logic [DW-1:0] dq_s;
  logic rb_s, sup_low_s;

  // pins from outside the clock domain
  fsp_sync #(.W(DW + 2), .INIT({{DW{1'b0}}, 1'b1, 1'b0})) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in({dq_in, ready_busy_n, supply_low}),
    .sync_out({dq_s, rb_s, sup_low_s})
  );

  function automatic logic is_drive(input fsp_state_e s);
    return (s == FSP_W_SET) || (s == FSP_W_LOW) || (s == FSP_W_END);
  endfunction

  always_comb begin
    next_state = state;
    next_wcnt = wcnt;
    next_pcnt = pcnt;
    next_op_addr = op_addr;
    next_op_wdata = op_wdata;
    next_rdata = rdata;
    next_status = status;
    next_first_tog = first_tog;
    next_have_first = have_first;
    next_polling = polling;
    next_poll_after = poll_after;
    next_pre_pend = pre_pend;
    next_rst_only = rst_only;
    next_chk_pend = chk_pend;
    next_status[`FSP_ST_READY] = rb_s;
    next_status[`FSP_ST_SUPPLY_LOW] = sup_low_s;
    if (polling) begin
      next_pcnt = pcnt + 32'h1;
    end
    unique case (state)
      FSP_IDLE: begin
        if (sw_wr && sw_addr == `FSP_REG_ADDR) begin
          next_op_addr = sw_wdata[AW-1:0];
        end
        if (sw_wr && sw_addr == `FSP_REG_WDATA) begin
          next_op_wdata = sw_wdata[DW-1:0];
        end
        if (sw_wr && sw_addr == `FSP_REG_CTRL && sw_wdata[7:0] != 8'h00) begin
          next_status[`FSP_ST_DONE] = 1'b0;
          next_status[`FSP_ST_FAIL] = 1'b0;
          next_status[`FSP_ST_LOCK_ABORT] = 1'b0;
          next_status[`FSP_ST_REFUSED] = 1'b0;
          next_pcnt = 32'h0;
          next_have_first = 1'b0;
          next_poll_after = sw_wdata[`FSP_CTRL_POLL_AFTER];
          next_pre_pend = sw_wdata[`FSP_CTRL_PRECLR];
          next_rst_only = 1'b0;
          next_chk_pend = 1'b0;
          if (sup_low_s && !sw_wdata[`FSP_CTRL_HWRST]) begin
            // flash would drop it anyway; tell software to retry later
            next_status[`FSP_ST_REFUSED] = 1'b1;
          end else if (sw_wdata[`FSP_CTRL_HWRST]) begin
            next_wcnt = 4'h0;
            next_state = FSP_HW_RST;
          end else if (sw_wdata[`FSP_CTRL_SWRST]) begin
            next_pre_pend = 1'b1;
            next_rst_only = 1'b1;
            next_state = FSP_W_SET;
          end else if (sw_wdata[`FSP_CTRL_ERASE_ADD]) begin
            // hold window check: erase_timer_flag must still read zero
            next_chk_pend = 1'b1;
            next_wcnt = 4'h0;
            next_state = FSP_R_LOW;
          end else if (sw_wdata[`FSP_CTRL_WRITE]) begin
            next_state = FSP_W_SET;
          end else if (sw_wdata[`FSP_CTRL_POLL]) begin
            next_polling = 1'b1;
            next_wcnt = 4'h0;
            next_state = FSP_R_LOW;
          end else if (sw_wdata[`FSP_CTRL_READ]) begin
            next_wcnt = 4'h0;
            next_state = FSP_R_LOW;
          end
        end
      end
      FSP_W_SET: next_state = FSP_W_LOW;
      FSP_W_LOW: next_state = FSP_W_END;
      FSP_W_END: begin
        if (pre_pend) begin
          next_pre_pend = 1'b0;
          if (rst_only) begin
            next_rst_only = 1'b0;
            next_status[`FSP_ST_DONE] = 1'b1;
            next_state = FSP_IDLE;
          end else begin
            next_state = FSP_W_SET;
          end
        end else if (poll_after) begin
          // toggling is live from the strobe rise just made
          next_polling = 1'b1;
          next_have_first = 1'b0;
          next_pcnt = 32'h0;
          next_wcnt = 4'h0;
          next_state = FSP_R_LOW;
        end else begin
          next_status[`FSP_ST_DONE] = 1'b1;
          next_state = FSP_IDLE;
        end
      end
      FSP_R_LOW: begin
        next_wcnt = wcnt + 4'h1;
        if (wcnt == RD_CYC - 4'h1) begin
          next_state = FSP_R_END;
        end
      end
      FSP_R_END: begin
        // bits 0, 1 and 4 carry no status and are not interpreted
        next_rdata = dq_s;
        next_status[`FSP_ST_TIMEOUT] = dq_s[`FSP_DQ_TIMEOUT];
        next_status[`FSP_ST_ERASE_TMR] = dq_s[`FSP_DQ_ERASE_TMR];
        next_status[`FSP_ST_TOGGLE2] = dq_s[`FSP_DQ_TOGGLE2];
        next_wcnt = 4'h0;
        next_state = FSP_IDLE;
        if (chk_pend) begin
          next_chk_pend = 1'b0;
          if (dq_s[`FSP_DQ_ERASE_TMR]) begin
            next_status[`FSP_ST_REFUSED] = 1'b1;
          end else begin
            next_state = FSP_W_SET;
          end
        end else if (polling) begin
          next_first_tog = dq_s[`FSP_DQ_TOGGLE1];
          next_have_first = 1'b1;
          if (!have_first) begin
            next_state = FSP_R_LOW;
          end else if (dq_s[`FSP_DQ_TOGGLE1] == first_tog) begin
            // steady bit: finished, protected-block abort included
            next_polling = 1'b0;
            next_status[`FSP_ST_DONE] = 1'b1;
          end else if (dq_s[`FSP_DQ_TIMEOUT] || pcnt >= POLL_LIMIT) begin
            // still toggling after timeout: failed, flash needs a reset
            next_polling = 1'b0;
            next_status[`FSP_ST_FAIL] = 1'b1;
            next_pre_pend = 1'b1;
            next_rst_only = 1'b1;
            next_state = FSP_W_SET;
          end else begin
            next_state = FSP_R_LOW;
          end
        end else begin
          next_status[`FSP_ST_DONE] = 1'b1;
        end
      end
      FSP_HW_RST: begin
        next_wcnt = wcnt + 4'h1;
        if (wcnt == RST_CYC - 4'h1) begin
          next_status[`FSP_ST_DONE] = 1'b1;
          next_state = FSP_IDLE;
        end
      end
    endcase
    // the flash drops an interrupted operation; abandon ours too
    if (sup_low_s && state != FSP_IDLE && state != FSP_HW_RST) begin
      next_state = FSP_IDLE;
      next_polling = 1'b0;
      next_pre_pend = 1'b0;
      next_rst_only = 1'b0;
      next_chk_pend = 1'b0;
      next_status[`FSP_ST_LOCK_ABORT] = 1'b1;
    end
    next_status[`FSP_ST_BUSY] = (next_state != FSP_IDLE);
    // pins follow the next state so they come straight from flops
    next_ce_n = !(is_drive(next_state) || next_state == FSP_R_LOW);
    next_oe_n = (next_state != FSP_R_LOW);
    next_we_n = (next_state != FSP_W_LOW);
    next_frst_n = (next_state != FSP_HW_RST);
    next_dq_oe = is_drive(next_state);
    next_flash_addr = next_op_addr;
    next_dq_out = next_pre_pend ? DW'(`FSP_SWRST_DATA) : next_op_wdata;
    next_sw_rdata = 32'h0;
    if (sw_rd) begin
      unique case (sw_addr)
        `FSP_REG_ADDR: next_sw_rdata = 32'(op_addr);
        `FSP_REG_WDATA: next_sw_rdata = 32'(op_wdata);
        `FSP_REG_RDATA: next_sw_rdata = 32'(rdata);
        `FSP_REG_STATUS: next_sw_rdata = 32'(status);
        default: next_sw_rdata = 32'h0;
      endcase
    end
  end

  // reset leaves every strobe high, so nothing is latched at power-up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= FSP_IDLE;
      wcnt <= 4'h0;
      pcnt <= 32'h0;
      op_addr <= '0;
      op_wdata <= '0;
      rdata <= '0;
      status <= `FSP_ST_RESET;
      first_tog <= 1'b0;
      have_first <= 1'b0;
      polling <= 1'b0;
      poll_after <= 1'b0;
      pre_pend <= 1'b0;
      rst_only <= 1'b0;
      chk_pend <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_rst_n <= 1'b1;
      flash_addr <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
      sw_rdata <= 32'h0;
    end else if (clk_en) begin
      state <= next_state;
      wcnt <= next_wcnt;
      pcnt <= next_pcnt;
      op_addr <= next_op_addr;
      op_wdata <= next_op_wdata;
      rdata <= next_rdata;
      status <= next_status;
      first_tog <= next_first_tog;
      have_first <= next_have_first;
      polling <= next_polling;
      poll_after <= next_poll_after;
      pre_pend <= next_pre_pend;
      rst_only <= next_rst_only;
      chk_pend <= next_chk_pend;
      flash_ce_n <= next_ce_n;
      flash_oe_n <= next_oe_n;
      flash_we_n <= next_we_n;
      flash_rst_n <= next_frst_n;
      flash_addr <= next_flash_addr;
      dq_out <= next_dq_out;
      dq_oe <= next_dq_oe;
      sw_rdata <= next_sw_rdata;
    end
  end

endmodule

// *** rtl/fsp_defines.svh ***
// register map, field positions, reset values and timing counts of the
// flash status poller; included by bare name, definitions only
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

// software port offsets (5-bit byte address)
`define FSP_REG_CTRL 5'h00
`define FSP_REG_ADDR 5'h04
`define FSP_REG_WDATA 5'h08
`define FSP_REG_RDATA 5'h0C
`define FSP_REG_STATUS 5'h10

// control register bits (write-one commands)
`define FSP_CTRL_WRITE 0
`define FSP_CTRL_READ 1
`define FSP_CTRL_POLL 2
`define FSP_CTRL_SWRST 3
`define FSP_CTRL_HWRST 4
`define FSP_CTRL_PRECLR 5
`define FSP_CTRL_ERASE_ADD 6
`define FSP_CTRL_POLL_AFTER 7

// status register bits
`define FSP_ST_BUSY 0
`define FSP_ST_DONE 1
`define FSP_ST_FAIL 2
`define FSP_ST_TIMEOUT 3
`define FSP_ST_ERASE_TMR 4
`define FSP_ST_TOGGLE2 5
`define FSP_ST_READY 6
`define FSP_ST_LOCK_ABORT 7
`define FSP_ST_REFUSED 8
`define FSP_ST_SUPPLY_LOW 9
`define FSP_ST_W 10
`define FSP_ST_RESET 10'h000

// data line positions of the status flags
`define FSP_DQ_POLL 7
`define FSP_DQ_TOGGLE1 6
`define FSP_DQ_TIMEOUT 5
`define FSP_DQ_ERASE_TMR 3
`define FSP_DQ_TOGGLE2 2

// software reset command data
`define FSP_SWRST_DATA 8'hF0

// timing
`define FSP_CLK_NS 100
`define FSP_T_ACC_NS 100
`define FSP_ACC_CYC ((`FSP_T_ACC_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_SYNC_CYC 2
`define FSP_T_RST_NS 500
`define FSP_RST_CYC ((`FSP_T_RST_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_OP_MAX_S 350
`define FSP_OP_MAX_CYC (64'd`FSP_OP_MAX_S * (64'd1000000000 / 64'd`FSP_CLK_NS))

`endif

// *** rtl/fsp_pkg.sv ***
// types of the flash status poller
// assumes nothing beyond a SystemVerilog compiler
package fsp_pkg;

  typedef enum logic [2:0] {
    FSP_IDLE,
    FSP_W_SET,
    FSP_W_LOW,
    FSP_W_END,
    FSP_R_LOW,
    FSP_R_END,
    FSP_HW_RST
  } fsp_state_e;

endpackage

// *** rtl/fsp_sync.sv ***
// two-flop synchroniser bank for pin inputs
// assumes clk, rst_n and clk_en shared with the poller
`timescale 1ns/1ps
module fsp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      sync_out <= INIT;
    end else if (clk_en) begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// *** testbench/fsp_poller_chk.sv ***
// pin timing checker of the flash status poller
// assumes the poller ports; bound at the foot of this file
`timescale 1ns/1ps
module fsp_poller_chk (
  // clock, reset, supply
  input wire logic clk,
  input wire logic rst_n,
  input wire logic supply_low,
  // flash pins
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_rst_n,
  input wire logic dq_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rst_pulse;
    $fell(flash_rst_n) |-> (!flash_rst_n)[*5] ##1 flash_rst_n;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse length wrong");
  property p_rst_quiet;
    !flash_rst_n |-> flash_ce_n && flash_we_n;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("bus cycle during reset");
  property p_we_in_ce;
    !flash_we_n |-> !flash_ce_n && dq_oe;
  endproperty
  a_we_in_ce: assert property (p_we_in_ce) else $error("write strobe outside cycle");
  property p_we_pulse;
    disable iff (!rst_n || supply_low) $fell(flash_we_n) |=> flash_we_n && !flash_ce_n;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe width wrong");
  property p_oe_read;
    disable iff (!rst_n || supply_low)
    $fell(flash_oe_n) |-> (!flash_oe_n && !flash_ce_n)[*3] ##1 flash_oe_n;
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("read strobe width wrong");
  property p_dq_release;
    !flash_oe_n |-> !dq_oe && flash_we_n;
  endproperty
  a_dq_release: assert property (p_dq_release) else $error("data driven in read");
  property p_poll_gap;
    $rose(flash_oe_n) |-> flash_ce_n;
  endproperty
  a_poll_gap: assert property (p_poll_gap) else $error("chip select held between reads");
  property p_lockout;
    supply_low[*3] |=> flash_we_n && flash_oe_n;
  endproperty
  a_lockout: assert property (p_lockout) else $error("strobe during lockout");
  c_write: cover property ($rose(flash_we_n));
  c_read: cover property ($rose(flash_oe_n));
  c_reset: cover property ($fell(flash_rst_n));
endmodule

bind fsp_poller fsp_poller_chk fsp_poller_chk_i (.clk(clk), .rst_n(rst_n),
  .supply_low(supply_low), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n), .flash_rst_n(flash_rst_n), .dq_oe(dq_oe));

// *** testbench/fsp_flash_model.sv ***
// behavioural flash: toggling status while busy, open-drain ready line
// assumes one write cycle per command; low byte 0xF0 is the software reset
`timescale 1ns/1ps
module fsp_flash_model (
  // strobes and buses
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rst_pin_n,
  input wire logic [19:0] addr,
  input wire logic [15:0] dq_w,
  output logic [15:0] dq_r,
  output logic rb_low,
  // scenario knobs
  input wire logic supply_low,
  input wire logic fail_mode,
  input wire logic [7:0] busy_reads
);
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0000, tgt = 16'h0000;
  logic busy = 1'b0, failed = 1'b0, tog = 1'b0;
  logic [7:0] left = 8'h00;
  logic [3:0] ta = 4'h0;
  initial foreach (mem[i]) mem[i] = 16'h0000;
  // released bus shows the inverse so a stale value never passes
  assign dq_r = (!ce_n && !oe_n) ? last : ~last;
  assign rb_low = busy | failed;
  always @(posedge we_n) begin
    if (!ce_n && rst_pin_n && !supply_low) begin
      if (dq_w[7:0] == 8'hF0) begin
        busy = 1'b0;
        failed = 1'b0;
      end else if (!busy && !failed) begin
        busy = 1'b1;
        ta = addr[3:0];
        tgt = dq_w;
        left = busy_reads;
      end
    end
  end
  always @(negedge rst_pin_n or posedge supply_low) begin
    busy = 1'b0;
    failed = 1'b0;
  end
  always @(negedge oe_n) begin
    #1;
    if (!ce_n) begin
      if (busy && left == 8'h00) begin
        busy = 1'b0;
        failed = fail_mode;
        if (!fail_mode)
          mem[ta] = tgt;
      end else if (busy)
        left = left - 8'h01;
      if (busy || failed) begin
        tog = ~tog;
        last = {8'h00, ~tgt[7], tog, failed, 1'b0, failed, 1'b1, 2'b00};
      end else
        last = mem[addr[3:0]];
    end
  end
endmodule

// *** testbench/fsp_poller_tb.sv ***
// self-checking bench of the flash status poller against the flash model
// assumes the poller, its defines, the model and the bound checker
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fsp_poller_tb;
  logic clk = 1'b0, rst_n = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0, supply_low = 1'b0;
  logic fail_mode = 1'b0, flash_ce_n, flash_oe_n, flash_we_n, flash_rst_n, dq_oe, rb_low;
  logic [4:0] sw_addr = 5'h00;
  logic [31:0] sw_wdata = 32'h0, sw_rdata, st, lfsr = 32'h2C56A8E6;
  logic [19:0] flash_addr;
  logic [15:0] dq_in, dq_out, wd;
  logic [7:0] busy_reads = 8'h02;
  wire ready_busy_n;
  int err_count = 0, comparisons = 0;
  always #50 clk = ~clk;
  assign ready_busy_n = rb_low ? 1'b0 : 1'b1; // sink or pull-up
  fsp_poller #(.POLL_LIMIT(32'd200)) fsp_poller_i (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_rst_n(flash_rst_n), .flash_addr(flash_addr), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .ready_busy_n(ready_busy_n), .supply_low(supply_low));
  fsp_flash_model fsp_flash_model_i (.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
    .rst_pin_n(flash_rst_n), .addr(flash_addr), .dq_w(dq_out), .dq_r(dq_in), .rb_low(rb_low),
    .supply_low(supply_low), .fail_mode(fail_mode), .busy_reads(busy_reads));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_st(input logic done, input logic fail, input logic [15:0] q);
    return {22'h0, 3'b000, 1'b1, q[2], q[3], q[5], fail, done, 1'b0};
  endfunction
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(negedge clk);
    d = sw_rdata;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 300; i++) begin
      rd(`FSP_REG_STATUS, st);
      if (st[`FSP_ST_BUSY] === 1'b0)
        return;
    end
    check(st, 32'h0);
    stop_test();
  endtask
  task automatic run(input logic [31:0] ctrl, input logic [19:0] a, input logic [15:0] d);
    wr(`FSP_REG_ADDR, {12'h0, a});
    wr(`FSP_REG_WDATA, {16'h0, d});
    wr(`FSP_REG_CTRL, ctrl);
    wait_idle();
    rd(`FSP_REG_STATUS, st);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(`FSP_REG_STATUS, st);
    check(st, 32'h40);
    rd(5'h14, st);
    check(st, 32'h0);
    // failing program: toggling with time-out, then automatic software reset
    fail_mode <= 1'b1;
    run(32'h81, 20'h00003, 16'h1234);
    rd(`FSP_REG_STATUS, st);
    check(st, 32'h7E);
    fail_mode <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      // bit 5 clear so finished data never looks like a time-out
      wd = (lfsr[15:0] | 16'h0001) & 16'hFFDF;
      busy_reads <= {5'h0, lfsr[18:16]};
      run(i[0] ? 32'hA1 : 32'h81, {16'h0, lfsr[23:20]}, wd);
      check(st, exp_st(1'b1, 1'b0, wd));
      run(32'h02, {16'h0, lfsr[23:20]}, 16'h0000);
      rd(`FSP_REG_RDATA, st);
      check(st, {16'h0, wd});
    end
    supply_low <= 1'b1;
    repeat (3) @(posedge clk);
    wr(`FSP_REG_CTRL, 32'h01);
    rd(`FSP_REG_STATUS, st);
    check(st & 32'h300, 32'h300);
    wr(`FSP_REG_CTRL, 32'h10);
    wait_idle();
    supply_low <= 1'b0;
    busy_reads <= 8'h40;
    repeat (3) @(posedge clk);
    wr(`FSP_REG_CTRL, 32'h81);
    repeat (12) @(posedge clk);
    supply_low <= 1'b1;
    wait_idle();
    check(st & 32'h80, 32'h80);
    supply_low <= 1'b0;
    busy_reads <= 8'h01;
    repeat (3) @(posedge clk);
    run(32'h81, 20'h00005, 16'h0F01);
    check(st, exp_st(1'b1, 1'b0, 16'h0F01));
    stop_test();
  end
endmodule
